/* File: inc/vsarb_pkg.sv */
// shared constants and types for the slot arbiter and acknowledge controller
package vsarb_pkg;

  // backplane geometry
  localparam int NSLOT      = 12;                  // slots 1..12, bit i is slot i+1
  localparam int NIRQ       = 7;                   // request levels 1..7
  localparam int VEC_W      = 8;                   // status/id byte width
  localparam int SLOT_IDX_W = 4;                   // width of a slot index
  localparam int LVL_W      = 3;                   // width of a level code
  localparam int SYNC_W     = 2 * NSLOT + NIRQ + 2 + VEC_W; // bits through the pin synchroniser

  // round robin window, slots 6 to 11 as slot numbers
  localparam int RR_FIRST_SLOT = 6;
  localparam int RR_LAST_SLOT  = 11;
  localparam logic [11:0] RR_MASK = 12'h7E0;       // bits 5..10

  // register byte offsets
  localparam logic [7:0] OFS_ARB_CFG   = 8'h00;    // scheme enables
  localparam logic [7:0] OFS_CPU_SLOTS = 8'h04;    // which slots hold processors
  localparam logic [7:0] OFS_ROUTE     = 8'h08;    // per-slot level three routing
  localparam logic [7:0] OFS_IRQ_STAT  = 8'h0C;    // live request levels
  localparam logic [7:0] OFS_IACK_CTRL = 8'h10;    // processor acknowledge
  localparam logic [7:0] OFS_IACK_STAT = 8'h14;    // acknowledge result
  localparam logic [7:0] OFS_ARB_STAT  = 8'h18;    // arbiter state

  // scheme enable bit positions in the config register
  localparam int CFG_STRAIGHT = 0;
  localparam int CFG_RR_CPU   = 1;
  localparam int CFG_RR_611   = 2;
  localparam int CFG_CPU_ROR  = 3;
  localparam int CFG_W        = 4;

  // fields of the acknowledge status register
  localparam int IST_BUSY   = 0;
  localparam int IST_DONE   = 1;
  localparam int IST_VEC_LO = 8;
  localparam int IST_LVL_LO = 16;

  // fields of the live interrupt status register
  localparam int IRS_ANY    = 3;
  localparam int IRS_LINES  = 4;

  // fields of the arbiter status register
  localparam int AST_BBSY   = 4;
  localparam int AST_GRANT  = 5;
  localparam int AST_OWN    = 6;

  // reset values
  localparam logic [CFG_W-1:0] RST_ARB_CFG   = 4'h1;   // straight priority only
  localparam logic [11:0]      RST_CPU_SLOTS = 12'h000;
  localparam logic [11:0]      RST_ROUTE     = 12'h000; // all slots on level zero
  localparam logic [11:0]      GRANT_IDLE_N  = 12'hFFF; // no grant driven

  // arbiter and acknowledge sequencer states
  typedef enum logic [2:0] {ARB_IDLE, ARB_GRANT, ARB_BUSY, ARB_OWN} vsarb_arb_t;
  typedef enum logic [2:0] {IK_IDLE, IK_WAIT_BUS, IK_ADDR, IK_STROBE, IK_RELEASE} vsarb_iack_t;

endpackage : vsarb_pkg

/* File: hdl/vsarb_sync.sv */
`timescale 1ns/1ns
// two flop synchroniser for a bundle of backplane inputs
module vsarb_sync #(
  parameter int W = 1
) (
  input  wire logic         pclk,
  input  wire logic         presetn,
  input  wire logic [W-1:0] din,
  input  wire logic [W-1:0] rst_val,
  output logic      [W-1:0] dout
);

  // stage one is only ever read by stage two
  logic [W-1:0] stage1;

  // both stages reset to zero whatever rst_val holds; rst_val is never loaded
  // and stage one xors din with the idle pattern, so no port feeds the async reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stage1 <= '0;
      dout   <= '0;
    end else begin
      stage1 <= din ^ rst_val;
      dout   <= stage1;
    end
  end

endmodule : vsarb_sync

/* File: hdl/vsarb_top.sv */
`timescale 1ns/1ns
// Notes on behaviour
// - one request in, one grant out per slot
// - bus clear never driven, never relied on
// - arbitrate level zero, or level three where routed
// - level three signals pending request to releasers
// - four schemes, several enabled together
// - reset: straight priority, lowest non-processor slot
// - scheme choice in read/write config register
// - per-slot routing of level zero or three
// - seven active-low interrupt request levels
// - same level: lowest slot wins
// - level seven highest down to level one
// - watch all request lines, tell processor
// - forward processor acknowledge toward requester
// - acknowledge: iack low, level on A03..A01
// - acknowledge ripples through slot daisy chain
module vsarb_top (
  input  wire logic                        pclk,
  input  wire logic                        presetn,
  // apb slave
  input  wire logic                        psel,
  input  wire logic                        penable,
  input  wire logic                        pwrite,
  input  wire logic [7:0]                  paddr,
  input  wire logic [31:0]                 pwdata,
  output logic      [31:0]                 prdata,
  output logic                             pready,
  output logic                             pslverr,
  // arbitration pins, active low, output enables active high
  input  wire logic [vsarb_pkg::NSLOT-1:0] slot_request_line_n,
  input  wire logic [vsarb_pkg::NSLOT-1:0] slot_request_l3_n,
  output logic      [vsarb_pkg::NSLOT-1:0] slot_grant_line_n,
  input  wire logic                        bbsy_i_n,
  output logic                             bbsy_o,
  output logic                             bbsy_oe,
  output logic                             br3_o,
  output logic                             br3_oe,
  output logic                             bus_clear_n,
  // interrupt pins
  input  wire logic [vsarb_pkg::NIRQ-1:0]  irq_n,
  output logic                             iack_o,
  output logic                             iack_oe,
  output logic                             iack_out_n,
  output logic      [2:0]                  addr_o,
  output logic                             addr_oe,
  input  wire logic                        dtack_n,
  input  wire logic [vsarb_pkg::VEC_W-1:0] data_i,
  // level towards the processor
  output logic                             irq_to_cpu
);

  // whole block state in one word
  typedef struct packed {
    vsarb_pkg::vsarb_arb_t             arb;        // arbiter state
    vsarb_pkg::vsarb_iack_t            ik;         // acknowledge sequencer
    logic [vsarb_pkg::NSLOT-1:0]       grant_n;    // slot grants
    logic [3:0]                        gidx;       // index of granted slot
    logic [vsarb_pkg::CFG_W-1:0]       cfg;        // scheme enables
    logic [vsarb_pkg::NSLOT-1:0]       cpu_slots;  // processor slot map
    logic [vsarb_pkg::NSLOT-1:0]       route;      // 1 = level three routed
    logic [3:0]                        ptr_rr;     // rotation start, window
    logic [3:0]                        ptr_cpu;    // rotation start, processors
    logic [2:0]                        lvl;        // level being acknowledged
    logic [vsarb_pkg::VEC_W-1:0]       vec;        // captured status/id
    logic                              done;       // sticky acknowledge done
    logic                              bbsy_oe;
    logic                              br3_oe;
    logic                              addr_oe;
    logic                              iack_oe;
    logic                              iack_out_n;
    logic                              irq_cpu;
    logic [31:0]                       prdata;
    logic                              pready;
    logic                              pslverr;
  } vsarb_state_t;

  vsarb_state_t st;                                // registered state
  vsarb_state_t next_st;                           // next state

  // synchronised pins, request and handshake lines stored inverted to active high
  logic [vsarb_pkg::SYNC_W-1:0] sync_in;
  logic [vsarb_pkg::SYNC_W-1:0] sync_idle;
  logic [vsarb_pkg::SYNC_W-1:0] sync_out;
  logic [vsarb_pkg::NSLOT-1:0]  req0_s;            // level zero requests
  logic [vsarb_pkg::NSLOT-1:0]  req3_s;            // level three requests
  logic [vsarb_pkg::NIRQ-1:0]   irq_s;             // live interrupt levels
  logic                         bbsy_s;            // bus busy seen
  logic                         dtack_s;           // acknowledge seen
  logic [vsarb_pkg::VEC_W-1:0]  data_s;            // status/id lines

  assign sync_in   = {~slot_request_line_n, ~slot_request_l3_n, ~irq_n, ~bbsy_i_n, ~dtack_n, data_i};
  assign sync_idle = '0;

  // every backplane pin crosses two flops before anything reads it
  vsarb_sync #(.W(vsarb_pkg::SYNC_W)) u_sync (
    .pclk    (pclk),
    .presetn (presetn),
    .din     (sync_in),
    .rst_val (sync_idle),
    .dout    (sync_out)
  );

  assign {req0_s, req3_s, irq_s, bbsy_s, dtack_s, data_s} = sync_out;

  // lowest set bit at or after st, wrapping; msb of result says found
  function automatic logic [4:0] vsarb_pick(input logic [11:0] v, input logic [3:0] start);
    logic [4:0] r;
    logic [3:0] k;
    r = '0;
    k = '0;
    for (int i = vsarb_pkg::NSLOT - 1; i >= 0; i--) begin
      k = 4'((int'(start) + i) % vsarb_pkg::NSLOT);
      if (v[k]) begin
        r = {1'b1, k};
      end
    end
    return r;
  endfunction : vsarb_pick

  // rotation start after a slot has been served
  function automatic logic [3:0] vsarb_after(input logic [3:0] idx);
    return (idx == 4'(vsarb_pkg::NSLOT - 1)) ? 4'h0 : 4'(idx + 4'h1);
  endfunction : vsarb_after

  // highest live level, zero when none
  function automatic logic [2:0] vsarb_top_level(input logic [6:0] lines);
    logic [2:0] l;
    l = '0;
    for (int i = 0; i < vsarb_pkg::NIRQ; i++) begin
      if (lines[i]) begin
        l = 3'(i + 1);                             // later, higher level overrides
      end
    end
    return l;
  endfunction : vsarb_top_level

  // arbitration terms
  logic [vsarb_pkg::NSLOT-1:0] req;                // routed requests
  logic [vsarb_pkg::NSLOT-1:0] rr_win;             // window slots in use
  logic [4:0]                  pick_fix;           // fixed group winner
  logic [4:0]                  pick_rr;            // window group winner
  logic [4:0]                  pick_cpu;           // processor group winner
  logic                        any_req;
  logic [3:0]                  win;                // overall winner
  logic [2:0]                  live_lvl;           // best pending level

  // each slot brings either its level zero or level three line, same rank
  assign req    = (st.route & req3_s) | (~st.route & req0_s);
  assign rr_win = st.cfg[vsarb_pkg::CFG_RR_611] ? vsarb_pkg::RR_MASK : '0;

  // non-processor slots first in slot order, then the window, then processors
  always_comb begin
    pick_fix = vsarb_pick(req & ~st.cpu_slots & ~rr_win, 4'h0);
    pick_rr  = vsarb_pick(req & ~st.cpu_slots & rr_win, st.ptr_rr);
    pick_cpu = vsarb_pick(req & st.cpu_slots,
                          st.cfg[vsarb_pkg::CFG_RR_CPU] ? st.ptr_cpu : 4'h0);
    any_req  = pick_fix[4] | pick_rr[4] | pick_cpu[4];
    if (pick_fix[4]) begin
      win = pick_fix[3:0];
    end else if (pick_rr[4]) begin
      win = pick_rr[3:0];
    end else begin
      win = pick_cpu[3:0];
    end
  end

  assign live_lvl = vsarb_top_level(irq_s);

  // apb decode
  logic        apb_go;                             // access phase, answer due
  logic        apb_hit;                            // offset is mapped
  logic [31:0] rd_word;                            // read mux
  logic        ack_write;                          // processor acknowledge
  logic        done_clear;                         // software clears done

  assign apb_go     = psel & penable & ~st.pready;
  assign ack_write  = apb_go & pwrite & (paddr == vsarb_pkg::OFS_IACK_CTRL) & pwdata[0];
  assign done_clear = apb_go & pwrite & (paddr == vsarb_pkg::OFS_IACK_STAT) & pwdata[vsarb_pkg::IST_DONE];

  // read data and address check
  always_comb begin
    rd_word = '0;
    apb_hit = 1'b1;
    unique case (paddr)
      vsarb_pkg::OFS_ARB_CFG:   rd_word[vsarb_pkg::CFG_W-1:0] = st.cfg;
      vsarb_pkg::OFS_CPU_SLOTS: rd_word[11:0] = st.cpu_slots;
      vsarb_pkg::OFS_ROUTE:     rd_word[11:0] = st.route;
      vsarb_pkg::OFS_IRQ_STAT: begin
        rd_word[2:0] = live_lvl;
        rd_word[vsarb_pkg::IRS_ANY] = |irq_s;
        rd_word[vsarb_pkg::IRS_LINES +: vsarb_pkg::NIRQ] = irq_s;
      end
      vsarb_pkg::OFS_IACK_CTRL: rd_word = '0;
      vsarb_pkg::OFS_IACK_STAT: begin
        rd_word[vsarb_pkg::IST_BUSY] = (st.ik != vsarb_pkg::IK_IDLE);
        rd_word[vsarb_pkg::IST_DONE] = st.done;
        rd_word[vsarb_pkg::IST_VEC_LO +: vsarb_pkg::VEC_W] = st.vec;
        rd_word[vsarb_pkg::IST_LVL_LO +: 3] = st.lvl;
      end
      vsarb_pkg::OFS_ARB_STAT: begin
        rd_word[3:0] = st.gidx;
        rd_word[vsarb_pkg::AST_BBSY] = bbsy_s;
        rd_word[vsarb_pkg::AST_GRANT] = (st.arb == vsarb_pkg::ARB_GRANT);
        rd_word[vsarb_pkg::AST_OWN] = (st.arb == vsarb_pkg::ARB_OWN);
      end
      default:                  apb_hit = 1'b0;    // unmapped, error answer
    endcase
  end

  // next state of the whole block
  always_comb begin
    next_st = st;

    // apb: one wait state, answer registered
    next_st.pready  = apb_go;
    next_st.pslverr = apb_go & ~apb_hit;
    if (apb_go) begin
      next_st.prdata = (pwrite || !apb_hit) ? 32'h0000_0000 : rd_word;
    end
    if (apb_go && pwrite && apb_hit) begin
      unique case (paddr)
        vsarb_pkg::OFS_ARB_CFG:   next_st.cfg = pwdata[vsarb_pkg::CFG_W-1:0];
        vsarb_pkg::OFS_CPU_SLOTS: next_st.cpu_slots = pwdata[11:0];
        vsarb_pkg::OFS_ROUTE:     next_st.route = pwdata[11:0];
        default:                  next_st.cfg = st.cfg;
      endcase
    end

    // processor notified while any level is live and no cycle runs
    next_st.irq_cpu = (|irq_s) & (st.ik == vsarb_pkg::IK_IDLE);

    // done is sticky; a fresh completion beats a clear in the same cycle
    if (done_clear) begin
      next_st.done = 1'b0;
    end

    // release-on-request hint: someone waits while the bus is held
    next_st.br3_oe = st.cfg[vsarb_pkg::CFG_CPU_ROR] & any_req & bbsy_s;

    // arbiter: a single grant, new one only once bus busy is released
    unique case (st.arb)
      vsarb_pkg::ARB_IDLE: begin
        if (!bbsy_s && st.ik == vsarb_pkg::IK_WAIT_BUS) begin
          next_st.arb     = vsarb_pkg::ARB_OWN;
          next_st.bbsy_oe = 1'b1;
        end else if (!bbsy_s && any_req) begin
          next_st.arb          = vsarb_pkg::ARB_GRANT;
          next_st.gidx         = win;
          next_st.grant_n      = vsarb_pkg::GRANT_IDLE_N;
          next_st.grant_n[win] = 1'b0;
          if (rr_win[win] && !st.cpu_slots[win]) begin
            next_st.ptr_rr = vsarb_after(win);
          end
          if (st.cpu_slots[win]) begin
            next_st.ptr_cpu = vsarb_after(win);
          end
        end
      end
      vsarb_pkg::ARB_GRANT: begin
        // the new master takes the bus and holds it busy
        if (bbsy_s) begin
          next_st.arb     = vsarb_pkg::ARB_BUSY;
          next_st.grant_n = vsarb_pkg::GRANT_IDLE_N;
        end else if (!req[st.gidx]) begin
          // request withdrawn before taking the bus
          next_st.arb     = vsarb_pkg::ARB_IDLE;
          next_st.grant_n = vsarb_pkg::GRANT_IDLE_N;
        end
      end
      vsarb_pkg::ARB_BUSY: begin
        // no bus clear exists; just wait for the master to let go
        if (!bbsy_s) begin
          next_st.arb = vsarb_pkg::ARB_IDLE;
        end
      end
      vsarb_pkg::ARB_OWN: begin
        if (st.ik == vsarb_pkg::IK_IDLE) begin
          next_st.arb = vsarb_pkg::ARB_BUSY;
        end
      end
      default: next_st.arb = vsarb_pkg::ARB_IDLE;
    endcase

    // acknowledge sequencer
    unique case (st.ik)
      vsarb_pkg::IK_IDLE: begin
        // a write while a cycle runs is ignored
        if (ack_write && live_lvl != 3'h0) begin
          next_st.ik  = vsarb_pkg::IK_WAIT_BUS;
          next_st.lvl = live_lvl;
        end
      end
      vsarb_pkg::IK_WAIT_BUS: begin
        if (st.arb == vsarb_pkg::ARB_OWN) begin
          next_st.ik      = vsarb_pkg::IK_ADDR;
          next_st.addr_oe = 1'b1;
        end
      end
      vsarb_pkg::IK_ADDR: begin
        // level settled a cycle before iack falls
        next_st.ik         = vsarb_pkg::IK_STROBE;
        next_st.iack_oe    = 1'b1;
        next_st.iack_out_n = 1'b0;
      end
      vsarb_pkg::IK_STROBE: begin
        if (dtack_s) begin
          next_st.vec        = data_s;
          next_st.ik         = vsarb_pkg::IK_RELEASE;
          next_st.iack_oe    = 1'b0;
          next_st.iack_out_n = 1'b1;
          next_st.addr_oe    = 1'b0;
        end
      end
      vsarb_pkg::IK_RELEASE: begin
        if (!dtack_s) begin
          next_st.ik      = vsarb_pkg::IK_IDLE;
          next_st.bbsy_oe = 1'b0;
          next_st.done    = 1'b1;                  // set wins over clear
        end
      end
      default: next_st.ik = vsarb_pkg::IK_IDLE;
    endcase
  end

  // state register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st            <= '0;
      st.arb        <= vsarb_pkg::ARB_IDLE;
      st.ik         <= vsarb_pkg::IK_IDLE;
      st.grant_n    <= vsarb_pkg::GRANT_IDLE_N;
      st.cfg        <= vsarb_pkg::RST_ARB_CFG;
      st.cpu_slots  <= vsarb_pkg::RST_CPU_SLOTS;
      st.route      <= vsarb_pkg::RST_ROUTE;
      st.iack_out_n <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  // ports straight from the state word; open drain levels are fixed low
  assign prdata            = st.prdata;
  assign pready            = st.pready;
  assign pslverr           = st.pslverr;
  assign slot_grant_line_n = st.grant_n;
  assign bbsy_oe           = st.bbsy_oe;
  assign bbsy_o            = 1'b0;
  assign br3_oe            = st.br3_oe;
  assign br3_o             = 1'b0;
  assign bus_clear_n       = 1'b1;
  assign iack_oe           = st.iack_oe;
  assign iack_o            = 1'b0;
  assign iack_out_n        = st.iack_out_n;
  assign addr_o            = st.lvl;
  assign addr_oe           = st.addr_oe;
  assign irq_to_cpu        = st.irq_cpu;

  // checks
  a_grant_onehot: assert property (@(posedge pclk) disable iff (!presetn)
    $onehot0(~st.grant_n)) else $error("more than one slot granted");

  a_grant_idle_bus: assert property (@(posedge pclk) disable iff (!presetn)
    $fell(st.grant_n[st.gidx]) |-> $past(!bbsy_s)) else $error("grant issued while bus busy");

  a_no_bus_clear: assert property (@(posedge pclk) disable iff (!presetn)
    bus_clear_n && !(st.grant_n != vsarb_pkg::GRANT_IDLE_N && st.arb == vsarb_pkg::ARB_OWN))
    else $error("bus clear driven or grant while self owned");

  a_grant_routed: assert property (@(posedge pclk) disable iff (!presetn)
    (st.arb == vsarb_pkg::ARB_IDLE && !bbsy_s && any_req && st.ik != vsarb_pkg::IK_WAIT_BUS)
    |=> !st.grant_n[st.gidx] && $past(req[win])) else $error("grant not given to routed request");

  a_fixed_lowest: assert property (@(posedge pclk) disable iff (!presetn)
    $fell(st.grant_n[st.gidx]) && $past(pick_fix[4]) |-> ($past(req & ~st.cpu_slots & ~rr_win)
    & ((12'h001 << st.gidx) - 12'h001)) == 12'h000) else $error("lower slot skipped");

  a_ror_hint: assert property (@(posedge pclk) disable iff (!presetn)
    br3_oe |-> $past(st.cfg[vsarb_pkg::CFG_CPU_ROR] && any_req && bbsy_s))
    else $error("level three hint without waiting request");

  a_addr_before_iack: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(iack_oe) |-> addr_oe && $past(addr_oe) && addr_o == $past(addr_o) && bbsy_oe)
    else $error("iack fell without level settled");

  a_level_highest: assert property (@(posedge pclk) disable iff (!presetn)
    (st.ik == vsarb_pkg::IK_IDLE && ack_write && live_lvl != 3'h0) |=>
    st.lvl == $past(live_lvl) && ($past(irq_s) >> st.lvl) == 7'h00)
    else $error("acknowledged level not the highest");

  a_chain_with_iack: assert property (@(posedge pclk) disable iff (!presetn)
    iack_out_n == !iack_oe) else $error("daisy chain start not tied to iack");

  a_vector_taken: assert property (@(posedge pclk) disable iff (!presetn)
    (st.ik == vsarb_pkg::IK_STROBE && dtack_s) |=> (st.vec == $past(data_s) && !iack_oe) ##1 !iack_oe)
    else $error("status/id byte not captured");

  a_cpu_notify: assert property (@(posedge pclk) disable iff (!presetn)
    (|irq_s && st.ik == vsarb_pkg::IK_IDLE) |=> irq_to_cpu) else $error("live request not signalled");

endmodule : vsarb_top

/* File: verif/vsarb_board.sv */
`timescale 1ns/1ns
// backplane boards: a bus master and one interrupter behind the chain
module vsarb_board (
  input  wire logic        pclk,
  input  wire logic [11:0] grant_n,
  input  wire logic        iack_in_n,
  input  wire logic [2:0]  addr,
  input  wire logic [2:0]  my_level,
  input  wire logic [7:0]  my_vector,
  output logic             bbsy_n,
  output logic             dtack_n,
  output logic [7:0]       data
);
  int   hold = 0;    // cycles left as master
  logic hit  = 0;    // level matched at chain fall
  initial begin
    bbsy_n = 1'h1;
    dtack_n = 1'h1;
    data = 8'h00;
  end
  // any grant makes this board master; busy held, then let go
  always @(posedge pclk) begin
    if (bbsy_n && grant_n !== 12'hFFF && hold == 0) hold <= 8;
    else if (hold > 0) hold <= hold - 1;
    bbsy_n <= !(hold > 1);
  end
  // level taken at the falling edge of the chain input
  always @(negedge iack_in_n) hit = (addr === my_level);
  // answer with the byte; released lines toggle so no stale value survives
  always @(posedge pclk) begin
    dtack_n <= !(!iack_in_n && hit);
    data <= (!iack_in_n && hit) ? my_vector : ~data;
  end
endmodule : vsarb_board

/* File: verif/vsarb_top_test.sv */
`timescale 1ns/1ns
// self-checking bench for slot arbitration and acknowledge cycles
module vsarb_top_test;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err;  // clock, reset, apb
  logic [7:0]  paddr, vec;                   // apb address, status/id lines
  logic [31:0] pwdata, prdata, rd;           // apb data, last read
  logic [11:0] req_n, req3_n, gnt_n;         // slot lines
  logic [6:0]  irq_n;                        // request levels
  logic [2:0]  addr;                         // level code lines
  logic        bbsy_oe, brd_n, dtack_n, iack_n, clr_n, cpu_irq, br3, iack_oe;
  int          fails, total_checks;          // tallies

  vsarb_top u_vsarb_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .slot_request_line_n(req_n), .slot_request_l3_n(req3_n), .slot_grant_line_n(gnt_n),
    .bbsy_i_n(brd_n & ~bbsy_oe), .bbsy_o(), .bbsy_oe(bbsy_oe), .br3_o(), .br3_oe(br3), .bus_clear_n(clr_n),
    .irq_n(irq_n), .iack_o(), .iack_oe(iack_oe), .iack_out_n(iack_n), .addr_o(addr), .addr_oe(),
    .dtack_n(dtack_n), .data_i(vec), .irq_to_cpu(cpu_irq));
  vsarb_board u_vsarb_board (.pclk(pclk), .grant_n(gnt_n), .iack_in_n(iack_n), .addr(addr),
    .my_level(3'h5), .my_vector(8'hA5), .bbsy_n(brd_n), .dtack_n(dtack_n), .data(vec));

  // free running clock
  initial begin
    pclk = 1'h0;
    forever #5 pclk = ~pclk;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // one apb transfer; idle edge after it so strobes never double-assign
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    @(posedge pclk);
    while (pready !== 1'h1) @(posedge pclk);
    rd = prdata;
    err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
    @(posedge pclk);
  endtask : apb

  // wait out any old grant, then the next one, bounded
  task automatic wait_grant(input logic [11:0] exp);
    for (int n = 0; n < 40 && gnt_n !== 12'hFFF; n++) @(posedge pclk);
    for (int n = 0; n < 40 && gnt_n === 12'hFFF; n++) @(posedge pclk);
    chk({20'h0, gnt_n}, {20'h0, exp});
  endtask : wait_grant

  task automatic print_verdict();
    if (fails == 0 && total_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : print_verdict

  task automatic t_regs();
    apb(1'h0, 8'h00, 32'h0);
    chk(rd, 32'h1);
    apb(1'h0, 8'h1C, 32'h0);
    chk({31'h0, err}, 32'h1);
    chk({31'h0, clr_n}, 32'h1);
    apb(1'h1, 8'h00, 32'hF);
    apb(1'h0, 8'h00, 32'h0);
    chk(rd, 32'hF);
  endtask : t_regs

  // slots 1 and 3 together, then slot 1 marked as a processor
  task automatic t_arb();
    req_n <= 12'hFFA;
    wait_grant(12'hFFE);
    req_n <= 12'hFFB;
    // slot 3 waits while slot 1 holds the bus: pending hint must show
    repeat (6) @(posedge pclk);
    chk({31'h0, br3}, 32'h1);
    wait_grant(12'hFFB);
    req_n <= 12'hFFF;
    apb(1'h1, 8'h04, 32'h1);
    req_n <= 12'hFFA;
    wait_grant(12'hFFB);
    req_n <= 12'hFFF;
    apb(1'h1, 8'h04, 32'h0);
    // slots 6 and 7 in the rotating window: served in turn, not slot 6 twice
    req_n <= 12'hF9F;
    wait_grant(12'hFDF);
    wait_grant(12'hFBF);
    wait_grant(12'hFDF);
    req_n <= 12'hFFF;
  endtask : t_arb

  // level three of slot 2 ignored until routed
  task automatic t_route();
    req3_n <= 12'hFFD;
    repeat (20) @(posedge pclk);
    chk({20'h0, gnt_n}, 32'hFFF);
    chk({31'h0, br3}, 32'h0);
    apb(1'h1, 8'h08, 32'h2);
    wait_grant(12'hFFD);
    req3_n <= 12'hFFF;
    apb(1'h1, 8'h08, 32'h0);
  endtask : t_route

  // levels 2 and 5 live; acknowledge runs for level 5
  task automatic t_irq();
    irq_n <= 7'h6D;
    repeat (8) @(posedge pclk);
    chk({31'h0, cpu_irq}, 32'h1);
    apb(1'h0, 8'h0C, 32'h0);
    chk({29'h0, rd[2:0]}, 32'h5);
    apb(1'h1, 8'h10, 32'h1);
    // bus taken by the controller itself before iack falls, level on the lines
    for (int n = 0; n < 40 && iack_oe !== 1'h1; n++) @(posedge pclk);
    chk({29'h0, addr}, 32'h5);
    chk({20'h0, gnt_n}, 32'hFFF);
    chk({30'h0, iack_oe, bbsy_oe}, 32'h3);
    rd = 32'h0;
    for (int i = 0; i < 30 && rd[1] !== 1'h1; i++) apb(1'h0, 8'h14, 32'h0);
    chk({31'h0, rd[1]}, 32'h1);
    chk({21'h0, rd[18:8]}, 32'h5A5);
    // sticky done flag cleared by writing one
    apb(1'h1, 8'h14, 32'h2);
    apb(1'h0, 8'h14, 32'h0);
    chk({31'h0, rd[1]}, 32'h0);
    irq_n <= 7'h7F;
  endtask : t_irq

  // main sequence
  initial begin
    fails = 0;
    total_checks = 0;
    // non-blocking so the reset edge lands after every process is waiting
    {presetn, psel, penable, pwrite, paddr, pwdata} <= '0;
    {req_n, req3_n, irq_n} <= '1;
    repeat (16) @(posedge pclk);
    presetn <= 1'h1;
    @(posedge pclk);
    t_regs();
    t_arb();
    t_route();
    t_irq();
    print_verdict();
  end

  // watchdog, far beyond the few hundred cycles expected
  initial begin
    #50000;
    fails++;
    print_verdict();
  end
endmodule : vsarb_top_test
